//--- rtl/acq_sequencer.sv
// Function
// - while designating, raise track permit once pointing error drops below 0.5 deg
// - sample lock valid discrete every half-second tick during designation
// - no lock after 60 rate commands: drop permit, raise alarm, await operator
// - lock during designation ends it and shows antenna angles for confirmation
// - after confirmation wait 2.5 s settle before enabling data reads
// - enter key without computer control selected starts manual acquisition
// - manual entry sets monitor inhibit, minimum deadband, raises track permit
// - monitor inhibit disables the radar angle monitoring function
// - proceed in manual checks antenna coverage limits, alarms if outside
// - manual success restores deadband, clears inhibit, sets manual acquired
// - search dwells 6 s on line of sight then each of six corners, repeating
// - search entry sets search flag, display, permit; permit reasserted per corner
// - line of sight recomputed each dwell with 1.5 s projection
// - search direction outside coverage in rendezvous: alarm, code, halt search
// - in coverage, gyro rate commands issue every half-second tick
// - antenna to +Z angle refreshed periodically into search display
// - lock during search stops pattern, notifies operator, awaits proceed
`default_nettype none
module acq_sequencer #(
   parameter int TICK_CYCLES = acq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // radar discretes
   input wire logic lock_valid_discrete,
   input wire logic computer_control_selected,
   output logic angle_track_permit,
   // gyro command loop
   output logic gyro_cmd_strobe,
   output logic [2:0] gyro_target_sel,
   output logic los_recompute_strobe,
   output logic [15:0] los_project_ms,
   // autopilot and monitor
   output logic min_deadband_sel,
   output logic angle_monitor_enable,
   // operator displays
   output logic program_alarm,
   output logic show_antenna_angles,
   output logic search_display,
   output logic [15:0] zangle_display,
   output logic data_read_enable
);
   import acq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
      hit = (adr[7:2] == off[7:2]);
   endfunction : hit

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            r[i*8 +: 8] = wd[i*8 +: 8];
      end
      merge = r;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // tick and discretes

   sense_if sn ();

   tick_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .sys_rst(sys_rst),
      .sn(sn.tick_src)
   );

   discrete_sync u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .lock_valid_discrete(lock_valid_discrete),
      .computer_control_selected(computer_control_selected),
      .sn(sn.sync_src)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      seq_state_t st;
      logic ack;
      logic [31:0] rdat;
      logic rnav;
      logic [31:0] geom;
      logic [15:0] zang_in;
      logic [15:0] zang_disp;
      logic permit;
      logic alarm;
      logic [7:0] acode;
      logic inhibit;
      logic min_db;
      logic man_acq;
      logic search;
      logic sdisp;
      logic show_ang;
      logic rd_en;
      logic [6:0] ncmd;
      logic [3:0] tcnt;
      logic [2:0] corner;
      logic gyro;
      logic recomp;
      logic [15:0] proj;
   } seq_t;

   seq_t q, d;

   logic req;
   logic wr;
   logic [4:0] cmd;
   logic [31:0] status_w;
   logic [31:0] count_w;

   assign req = wb_cyc_i & wb_stb_i;
   // a write lands on the edge where ack is sampled high
   assign wr = req & wb_we_i & q.ack;
   assign cmd = (wr && hit(wb_adr_i, REG_CMD) && wb_sel_i[0]) ? wb_dat_i[4:0] : 5'h0;

   assign status_w = {16'h0, q.rd_en, q.show_ang, q.sdisp, q.search, q.man_acq, q.min_db,
                      q.inhibit, q.permit, q.alarm, sn.auto_s, sn.lock_s, 2'h0, q.st};
   assign count_w = {q.zang_disp, 5'h0, q.corner, 1'h0, q.ncmd};

   always_comb
   begin
      d = q;
      d.gyro = 1'b0;
      d.recomp = 1'b0;

      ////////////////////////////////////////////////////////////////////////////
      // bus slave: ack one cycle after the request, dropped the cycle after
      d.ack = req & ~q.ack;
      if (req & ~q.ack & ~wb_we_i)
      begin
         if (hit(wb_adr_i, REG_CFG))
            d.rdat = {31'h0, q.rnav};
         else if (hit(wb_adr_i, REG_GEOM))
            d.rdat = q.geom;
         else if (hit(wb_adr_i, REG_ZANGLE))
            d.rdat = {16'h0, q.zang_in};
         else if (hit(wb_adr_i, REG_STATUS))
            d.rdat = status_w;
         else if (hit(wb_adr_i, REG_ALARM))
            d.rdat = {23'h0, q.alarm, q.acode};
         else if (hit(wb_adr_i, REG_COUNT))
            d.rdat = count_w;
         else
            d.rdat = 32'h0;
      end
      if (wr)
      begin
         if (hit(wb_adr_i, REG_CFG) && wb_sel_i[0])
            d.rnav = wb_dat_i[0];
         else if (hit(wb_adr_i, REG_GEOM))
            d.geom = merge(q.geom, wb_dat_i, wb_sel_i);
         else if (hit(wb_adr_i, REG_ZANGLE))
            d.zang_in = 16'(merge({16'h0, q.zang_in}, wb_dat_i, wb_sel_i));
         else if (hit(wb_adr_i, REG_ALARM) && wb_sel_i[1] && wb_dat_i[8])
            d.alarm = 1'b0;
      end

      ////////////////////////////////////////////////////////////////////////////
      // sequencer; an alarm raised below overrides a clear above
      if (cmd[CMD_ABORT])
      begin
         d.st = ST_IDLE;
         d.permit = 1'b0;
         d.search = 1'b0;
         d.sdisp = 1'b0;
         d.show_ang = 1'b0;
         d.rd_en = 1'b0;
         d.inhibit = 1'b0;
         d.min_db = 1'b0;
      end
      else
      begin
         case (q.st)
            ST_IDLE:
            begin
               if (cmd[CMD_ENTER] && !sn.auto_s)
               begin
                  d.st = ST_MANUAL;
                  d.inhibit = 1'b1;
                  d.min_db = 1'b1;
                  d.permit = 1'b1;
                  d.man_acq = 1'b0;
               end
               else if (cmd[CMD_DESIGNATE] && sn.auto_s)
               begin
                  // permit withheld so the radar answers the designate commands
                  d.st = ST_DESIGNATE;
                  d.permit = 1'b0;
                  d.ncmd = 7'h0;
                  d.show_ang = 1'b0;
                  d.rd_en = 1'b0;
                  d.man_acq = 1'b0;
               end
               else if (cmd[CMD_SEARCH])
               begin
                  d.st = ST_SEARCH;
                  d.search = 1'b1;
                  d.sdisp = 1'b1;
                  d.permit = 1'b1;
                  d.corner = 3'h0;
                  d.tcnt = 4'h0;
                  d.recomp = 1'b1;
                  d.proj = PROJECT_MS_W;
                  d.show_ang = 1'b0;
                  d.rd_en = 1'b0;
               end
            end
            ST_DESIGNATE:
            begin
               if (q.geom[15:0] < LOCK_ANGLE_CDEG)
                  d.permit = 1'b1;
               if (sn.tick)
               begin
                  if (sn.lock_s)
                  begin
                     d.st = ST_CONFIRM;
                     d.show_ang = 1'b1;
                  end
                  else if (q.ncmd == CMD_LIMIT)
                  begin
                     d.st = ST_IDLE;
                     d.permit = 1'b0;
                     d.alarm = 1'b1;
                     d.acode = ALARM_NO_LOCK;
                  end
                  else
                  begin
                     d.gyro = 1'b1;
                     d.ncmd = q.ncmd + 7'h1;
                  end
               end
            end
            ST_CONFIRM:
            begin
               if (cmd[CMD_PROCEED])
               begin
                  d.st = ST_SETTLE;
                  d.tcnt = 4'h0;
               end
            end
            ST_SETTLE:
            begin
               if (sn.tick)
               begin
                  if (q.tcnt == SETTLE_LAST)
                  begin
                     d.st = ST_READ;
                     d.rd_en = 1'b1;
                     d.show_ang = 1'b0;
                  end
                  else
                  begin
                     d.tcnt = q.tcnt + 4'h1;
                  end
               end
            end
            ST_READ:
            begin
               d.rd_en = 1'b1;
            end
            ST_MANUAL:
            begin
               if (cmd[CMD_PROCEED])
               begin
                  if (q.geom[GEOM_IN_LIMITS])
                  begin
                     d.st = ST_READ;
                     d.rd_en = 1'b1;
                     d.min_db = 1'b0;
                     d.inhibit = 1'b0;
                     d.man_acq = 1'b1;
                  end
                  else
                  begin
                     d.alarm = 1'b1;
                     d.acode = ALARM_MAN_LIMITS;
                  end
               end
            end
            ST_SEARCH:
            begin
               if (sn.tick)
               begin
                  if (sn.lock_s)
                  begin
                     d.st = ST_SEARCH_LOCK;
                     d.show_ang = 1'b1;
                  end
                  else if (q.rnav && !q.geom[GEOM_IN_COVER])
                  begin
                     d.st = ST_IDLE;
                     d.alarm = 1'b1;
                     d.acode = ALARM_SEARCH_COVER;
                     d.search = 1'b0;
                     d.sdisp = 1'b0;
                  end
                  else
                  begin
                     d.gyro = q.geom[GEOM_IN_COVER];
                     d.zang_disp = q.zang_in;
                     if (q.tcnt == DWELL_LAST)
                     begin
                        d.tcnt = 4'h0;
                        d.corner = (q.corner == CORNER_LAST) ? 3'h0 : q.corner + 3'h1;
                        d.permit = 1'b1;
                        d.recomp = 1'b1;
                        d.proj = PROJECT_MS_W;
                     end
                     else
                     begin
                        d.tcnt = q.tcnt + 4'h1;
                     end
                  end
               end
            end
            ST_SEARCH_LOCK:
            begin
               if (cmd[CMD_PROCEED])
               begin
                  d.st = ST_SETTLE;
                  d.tcnt = 4'h0;
                  d.search = 1'b0;
                  d.sdisp = 1'b0;
               end
            end
            default:
            begin
               d.st = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign wb_dat_o = q.rdat;
   assign wb_ack_o = q.ack;
   assign angle_track_permit = q.permit;
   assign gyro_cmd_strobe = q.gyro;
   assign gyro_target_sel = q.corner;
   assign los_recompute_strobe = q.recomp;
   assign los_project_ms = q.proj;
   assign min_deadband_sel = q.min_db;
   assign angle_monitor_enable = ~q.inhibit;
   assign program_alarm = q.alarm;
   assign show_antenna_angles = q.show_ang;
   assign search_display = q.sdisp;
   assign zangle_display = q.zang_disp;
   assign data_read_enable = q.rd_en;
endmodule : acq_sequencer
`default_nettype wire

//--- rtl/acq_pkg.sv
`default_nettype none
package acq_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and time base
   localparam int CLK_KHZ = 125000;
   localparam int TICK_MS = 500;
   // CLK_KHZ is also the count of cycles in one millisecond
   localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
   localparam int DWELL_MS = 6000;
   localparam int SETTLE_MS = 2500;
   localparam int PROJECT_MS = 1500;
   // a dwell is a longest time, the settle a least time
   localparam int DWELL_TICKS = DWELL_MS / TICK_MS;
   localparam int SETTLE_TICKS = (SETTLE_MS + TICK_MS - 1) / TICK_MS;
   localparam logic [3:0] DWELL_LAST = 4'(DWELL_TICKS - 1);
   localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_TICKS - 1);
   localparam logic [15:0] PROJECT_MS_W = 16'(PROJECT_MS);

   ////////////////////////////////////////////////////////////////////////////////
   // sequencing limits
   localparam logic [6:0] CMD_LIMIT = 7'd60;
   localparam logic [15:0] LOCK_ANGLE_CDEG = 16'h0032;
   localparam logic [2:0] CORNER_LAST = 3'h6;

   ////////////////////////////////////////////////////////////////////////////////
   // register map, byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_GEOM = 8'h08;
   localparam logic [7:0] REG_ZANGLE = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_ALARM = 8'h14;
   localparam logic [7:0] REG_COUNT = 8'h18;

   // command bits of REG_CMD
   localparam int CMD_DESIGNATE = 0;
   localparam int CMD_ENTER = 1;
   localparam int CMD_PROCEED = 2;
   localparam int CMD_SEARCH = 3;
   localparam int CMD_ABORT = 4;
   // fields of REG_GEOM
   localparam int GEOM_IN_LIMITS = 16;
   localparam int GEOM_IN_COVER = 17;

   // alarm codes
   localparam logic [7:0] ALARM_NONE = 8'h00;
   localparam logic [7:0] ALARM_NO_LOCK = 8'h01;
   localparam logic [7:0] ALARM_MAN_LIMITS = 8'h02;
   localparam logic [7:0] ALARM_SEARCH_COVER = 8'h03;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DESIGNATE,
      ST_CONFIRM,
      ST_SETTLE,
      ST_READ,
      ST_MANUAL,
      ST_SEARCH,
      ST_SEARCH_LOCK
   } seq_state_t;

endpackage : acq_pkg
`default_nettype wire

//--- rtl/sense_if.sv
`default_nettype none
interface sense_if;
   logic tick;
   logic lock_s;
   logic auto_s;
   modport tick_src (output tick);
   modport sync_src (output lock_s, output auto_s);
   modport seq (input tick, input lock_s, input auto_s);
endinterface : sense_if
`default_nettype wire

//--- rtl/tick_gen.sv
`default_nettype none
module tick_gen #(
   parameter int TICK_CYCLES = acq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // tick out
   sense_if.tick_src sn
);
   import acq_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } tick_state_t;

   tick_state_t q, d;

   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == 32'(TICK_CYCLES - 1))
      begin
         d.cnt = 32'h0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   assign sn.tick = q.tick;
endmodule : tick_gen
`default_nettype wire

//--- rtl/discrete_sync.sv
`default_nettype none
module discrete_sync (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // radar discretes, asynchronous
   input wire logic lock_valid_discrete,
   input wire logic computer_control_selected,
   // synchronised copies
   sense_if.sync_src sn
);
   typedef struct packed {
      logic [1:0] m1;
      logic [1:0] m2;
   } sync_state_t;

   sync_state_t q, d;

   always_comb
   begin
      d = q;
      d.m1 = {lock_valid_discrete, computer_control_selected};
      d.m2 = q.m1;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= '0;
      else
         q <= d;
   end

   assign sn.lock_s = q.m2[1];
   assign sn.auto_s = q.m2[0];
endmodule : discrete_sync
`default_nettype wire

//--- tb/acq_props.sv
`default_nettype none
module acq_props
   import acq_pkg::*;
#(
   parameter int TICK_CYCLES = acq_pkg::TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus handshake
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // sequencer outputs
   input wire logic angle_track_permit,
   input wire logic gyro_cmd_strobe,
   input wire logic [2:0] gyro_target_sel,
   input wire logic los_recompute_strobe,
   input wire logic [15:0] los_project_ms,
   input wire logic min_deadband_sel,
   input wire logic angle_monitor_enable,
   input wire logic program_alarm,
   input wire logic show_antenna_angles,
   input wire logic search_display,
   input wire logic data_read_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   // cycles since the last rate command; 0 until the first, so no false gap after reset
   logic [31:0] gap_q;
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
         gap_q <= 32'h0;
      else if (gyro_cmd_strobe)
         gap_q <= 32'h1;
      else if (gap_q != 32'h0)
         gap_q <= gap_q + 32'h1;
   ////////////////////////////////////////
   a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered after one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_rate_pulse: assert property (gyro_cmd_strobe |=> !gyro_cmd_strobe)
      else $error("rate command strobe longer than one cycle");
   a_rate_spacing: assert property (
      gyro_cmd_strobe && gap_q != 32'h0 |-> gap_q >= TICK_CYCLES)
      else $error("rate commands closer than one tick");
   a_corner_range: assert property (gyro_target_sel <= CORNER_LAST)
      else $error("pointing target beyond last corner");
   a_corner_step: assert property (
      $changed(gyro_target_sel) && gyro_target_sel != 3'h0
      |-> ##[0:1] (los_recompute_strobe && angle_track_permit))
      else $error("corner change without recompute and permit");
   a_project_ahead: assert property (los_recompute_strobe |=> los_project_ms == PROJECT_MS_W)
      else $error("projection time wrong after recompute");
   a_search_entry: assert property (
      $rose(search_display) |-> ##[0:1] (angle_track_permit && los_recompute_strobe))
      else $error("search entry without permit and recompute");
   a_manual_permit: assert property ($rose(min_deadband_sel) |-> angle_track_permit)
      else $error("manual entry without track permit");
   a_inhibit_pair: assert property (angle_monitor_enable != min_deadband_sel)
      else $error("monitor inhibit and minimum deadband disagree");
   a_confirm_quiet: assert property (show_antenna_angles |-> !gyro_cmd_strobe)
      else $error("rate command while angles shown");
   c_lock_seen: cover property ($rose(show_antenna_angles));
   c_reads_on: cover property ($rose(data_read_enable));
   c_alarm: cover property ($rose(program_alarm));
endmodule : acq_props

bind acq_sequencer acq_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .angle_track_permit(angle_track_permit),
   .gyro_cmd_strobe(gyro_cmd_strobe), .gyro_target_sel(gyro_target_sel),
   .los_recompute_strobe(los_recompute_strobe), .los_project_ms(los_project_ms),
   .min_deadband_sel(min_deadband_sel), .angle_monitor_enable(angle_monitor_enable),
   .program_alarm(program_alarm), .show_antenna_angles(show_antenna_angles),
   .search_display(search_display), .data_read_enable(data_read_enable));
`default_nettype wire

//--- tb/radar_model.sv
`default_nettype none
module radar_model #(
   parameter int LOCK_CYCLES = 40
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // scenario controls
   input wire logic target,
   input wire logic auto_req,
   // discretes
   input wire logic angle_track_permit,
   output logic lock_valid_discrete,
   output logic computer_control_selected,
   output logic no_track
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] search_q;
   // a control handover restarts the range search, so lock never survives it
   always_ff @(posedge clk or posedge sys_rst)
      if (sys_rst)
      begin
         search_q <= 8'h0;
         computer_control_selected <= 1'b0;
      end
      else
      begin
         computer_control_selected <= auto_req;
         if (!angle_track_permit || !target || auto_req != computer_control_selected)
            search_q <= 8'h0;
         else if (search_q != 8'(LOCK_CYCLES))
            search_q <= search_q + 8'h1;
      end
   assign lock_valid_discrete = (search_q == 8'(LOCK_CYCLES));
   assign no_track = !lock_valid_discrete;
endmodule : radar_model
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
   $display("FAIL %s expected %0h seen %0h", n, e, s); end end
`define WT(x, b) begin k = 0; while (!(x) && k < (b)) begin @(posedge clk); #1; k++; end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import acq_pkg::*;
   // short tick keeps the 60-command timeout run brief
   localparam int T = 16;
   int mismatches = 0;
   int n_tests = 0;
   int k, g, c, p;
   logic clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic target = 1'b1, auto_req = 1'b1, no_trk;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rv, dat_o;
   logic ack, lock, ccs, permit, gyro, recomp, deadband, mon_en, alarm, angles, sdisp, rd_en;
   logic [2:0] tsel;
   logic [15:0] proj, zdisp;
   always #4 clk = ~clk;
   acq_sequencer #(.TICK_CYCLES(T)) u_dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .lock_valid_discrete(lock),
      .computer_control_selected(ccs), .angle_track_permit(permit), .gyro_cmd_strobe(gyro),
      .gyro_target_sel(tsel), .los_recompute_strobe(recomp), .los_project_ms(proj),
      .min_deadband_sel(deadband), .angle_monitor_enable(mon_en), .program_alarm(alarm),
      .show_antenna_angles(angles), .search_display(sdisp), .zangle_display(zdisp),
      .data_read_enable(rd_en));
   radar_model u_radar (.clk(clk), .sys_rst(sys_rst), .target(target), .auto_req(auto_req),
      .angle_track_permit(permit), .lock_valid_discrete(lock),
      .computer_control_selected(ccs), .no_track(no_trk));
   ////////////////////////////////////////
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      @(posedge clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
      forever
      begin
         @(posedge clk);
         #1;
         if (ack === 1'b1) break;
      end
      rv = dat_o;
      @(posedge clk);
      {cyc, stb, we} <= 3'b000;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc_n
   task automatic clr;
      bus(1'b1, REG_ALARM, 32'h100, 4'h2);
      cyc_n(1);
      `CHK("alarm_clear", 1'b0, alarm)
   endtask : clr
   ////////////////////////////////////////
   task automatic t_regs;
      wr(8'h1c, 32'hffff_ffff);
      rd(8'h1c);
      `CHK("unmapped", 32'h0, rv)
      wr(REG_CFG, 32'h1);
      rd(REG_CFG);
      `CHK("cfg", 32'h1, rv)
      rd(REG_CMD);
      `CHK("cmd_read", 32'h0, rv)
      rd(REG_STATUS);
      `CHK("status_idle", 32'h40, rv)
      wr(REG_CFG, 32'h0);
      $display("done regs");
   endtask : t_regs
   task automatic t_desig;
      wr(REG_GEOM, 32'h0003_0032);
      wr(REG_CMD, 32'h1);
      cyc_n(4);
      `CHK("permit_edge", 1'b0, permit)
      wr(REG_GEOM, 32'h0003_0031);
      cyc_n(2);
      `CHK("permit", 1'b1, permit)
      `WT(angles === 1'b1, 10 * T)
      `CHK("angles", 1'b1, angles)
      rd(REG_STATUS);
      `CHK("confirm", 3'h2, rv[2:0])
      wr(REG_CMD, 32'h4);
      `WT(rd_en === 1'b1, 6 * T)
      `CHK("settle", 1'b1, (k >= 4 * T && k <= 5 * T + 2))
      wr(REG_CMD, 32'h10);
      cyc_n(2);
      `CHK("abort", 1'b0, permit)
      $display("done designate");
   endtask : t_desig
   task automatic t_nolock;
      target <= 1'b0;
      wr(REG_GEOM, 32'h0003_0010);
      wr(REG_CMD, 32'h1);
      g = 0;
      k = 0;
      while (alarm !== 1'b1 && k < 70 * T)
      begin
         @(posedge clk);
         #1;
         k++;
         if (gyro === 1'b1) g++;
      end
      `CHK("cmds", 60, g)
      `CHK("permit_drop", 1'b0, permit)
      rd(REG_ALARM);
      `CHK("code", 9'h101, rv[8:0])
      clr();
      $display("done nolock");
   endtask : t_nolock
   task automatic t_manual;
      wr(REG_CMD, 32'h2);
      rd(REG_STATUS);
      `CHK("enter_refused", 3'h0, rv[2:0])
      auto_req <= 1'b0;
      wr(REG_GEOM, 32'h0);
      cyc_n(4);
      wr(REG_CMD, 32'h2);
      cyc_n(2);
      `CHK("deadband", 1'b1, deadband)
      `CHK("permit", 1'b1, permit)
      `CHK("inhibit", 1'b0, mon_en)
      wr(REG_CMD, 32'h4);
      cyc_n(2);
      `CHK("limit_alarm", 1'b1, alarm)
      rd(REG_ALARM);
      `CHK("limit_code", 8'h02, rv[7:0])
      clr();
      wr(REG_GEOM, 32'h0001_0000);
      wr(REG_CMD, 32'h4);
      rd(REG_STATUS);
      `CHK("acquired", 1'b1, rv[11])
      `CHK("deadband_off", 1'b0, deadband)
      `CHK("monitor_on", 1'b1, mon_en)
      wr(REG_CMD, 32'h10);
      auto_req <= 1'b1;
      cyc_n(4);
      $display("done manual");
   endtask : t_manual
   task automatic t_search;
      target <= 1'b0;
      wr(REG_CFG, 32'h1);
      wr(REG_GEOM, 32'h0002_0000);
      wr(REG_ZANGLE, 32'h0123);
      wr(REG_CMD, 32'h8);
      cyc_n(1);
      `CHK("display", 1'b1, sdisp)
      `CHK("permit", 1'b1, permit)
      p = 0;
      for (c = 1; c < 8; c++)
      begin
         g = 0;
         k = 0;
         while (tsel === 3'(p) && k < 13 * T)
         begin
            @(posedge clk);
            #1;
            k++;
            if (gyro === 1'b1) g++;
         end
         `CHK("corner", 3'(c % 7), tsel)
         if (c > 1) `CHK("dwell", 12 * T, k)
         if (c > 1) `CHK("rate_cmds", 12, g)
         p = c % 7;
      end
      `CHK("zangle", 16'h0123, zdisp)
      target <= 1'b1;
      cyc_n(8 * T);
      rd(REG_STATUS);
      `CHK("search_lock", 3'h7, rv[2:0])
      `CHK("no_track", 1'b0, no_trk)
      g = 0;
      repeat (3 * T)
      begin
         @(posedge clk);
         #1;
         if (gyro === 1'b1) g++;
      end
      `CHK("halted", 0, g)
      wr(REG_CMD, 32'h4);
      rd(REG_STATUS);
      `CHK("to_settle", 3'h3, rv[2:0])
      wr(REG_CMD, 32'h10);
      cyc_n(2);
      `CHK("display_off", 1'b0, sdisp)
      $display("done search");
   endtask : t_search
   task automatic t_cover;
      target <= 1'b0;
      wr(REG_GEOM, 32'h0);
      wr(REG_CMD, 32'h8);
      `WT(alarm === 1'b1, 3 * T)
      `CHK("cover_alarm", 1'b1, alarm)
      rd(REG_ALARM);
      `CHK("cover_code", 8'h03, rv[7:0])
      `CHK("halted", 1'b0, sdisp)
      clr();
      $display("done cover");
   endtask : t_cover
   ////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs();
      t_desig();
      t_nolock();
      t_manual();
      t_search();
      t_cover();
      report_and_stop();
   end
   // roughly seven times the expected run of about 3000 cycles
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
